// file: dv/gate_drive_model.sv
// Behavioural gate-drive stage that takes the PWM pins without using them and raises a trip on command.
`timescale 1ns/10ps
`default_nettype none
module gate_drive_model (
   input  wire logic       clk_sys,    // System clock.
   input  wire logic       rstn,       // Reset, active low.
   input  wire logic [4:0] pwm_in,     // Gate commands from the unit.
   input  wire logic       fault_req,  // Bench asks for an overcurrent fault.
   output var  logic       trip_pin_n  // Trip line, low while faulted.
);
   // The trip line is driven at all times, so it never floats between faults.
   always_ff @(posedge clk_sys or negedge rstn) begin
      if (!rstn) begin
         trip_pin_n <= 1'b1;
      end else begin
         trip_pin_n <= ~fault_req;
      end
   end
endmodule
`default_nettype wire

// file: dv/tb_three_pair_pwm_compare_unit.sv
// Self-checking testbench for the three-pair PWM compare unit.
`timescale 1ns/10ps
`default_nettype none
module tb_three_pair_pwm_compare_unit
   import pwm_unit_pkg::*;
;
   logic        clk_sys, rstn, we_i, cyc_i, stb_i, ack_o, trip_pin_n, irq_o, fault_req;
   logic [31:0] adr_i, dat_i, dat_o;
   logic [3:0]  sel_i;
   logic [4:0]  pwm_out;
   logic [31:0] exp_q [$];
   logic [31:0] rv [3][4];
   int          num_errors = 0;
   int          num_checks = 0;
   int          seed = 32'h98d2a0e0;
   int          pv [3][4] = '{'{1, 4, 3, 7}, '{2, 6, 4, 9}, '{2, 5, 0, 7}};
   logic [11:0] bctl [6] = '{12'h003, 12'h013, 12'h203, 12'h207, 12'h223, 12'h227};
   logic [3:0]  bmsk [6] = '{4'hf, 4'hf, 4'h3, 4'hc, 4'hc, 4'h3};
   logic [3:0]  bexp [6] = '{4'hf, 4'h5, 4'h0, 4'h0, 4'hc, 4'h3};

   three_pair_pwm_compare_unit DUT (.clk_sys(clk_sys), .rstn(rstn), .adr_i(adr_i),
      .dat_i(dat_i), .dat_o(dat_o), .we_i(we_i), .sel_i(sel_i), .cyc_i(cyc_i),
      .stb_i(stb_i), .ack_o(ack_o), .trip_pin_n(trip_pin_n), .pwm_out(pwm_out),
      .irq_o(irq_o));
   gate_drive_model partner (.clk_sys(clk_sys), .rstn(rstn), .pwm_in(pwm_out),
      .fault_req(fault_req), .trip_pin_n(trip_pin_n));

   initial begin
      clk_sys = 1'b0;
      forever #12.5 clk_sys = ~clk_sys;
   end

   task automatic end_sim();
      $display("Checks %0d, errors %0d", num_checks, num_errors);
      if (num_errors == 0 && num_checks > 0) begin
         $display("Simulation passed");
      end else begin
         $display("Simulation failed");
      end
      $finish;
   endtask

   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      num_checks++;
      if (seen !== exp) begin
         num_errors++;
         $display("Error at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask

   // The master never assumes a latency; only the watchdog ends a wait.
   task automatic wb(input logic [31:0] a, input logic [31:0] d, input logic w,
                     input logic [3:0] s);
      @(posedge clk_sys);
      adr_i <= a;
      dat_i <= d;
      we_i  <= w;
      sel_i <= s;
      cyc_i <= 1'b1;
      stb_i <= 1'b1;
      do begin
         @(posedge clk_sys);
      end while (ack_o !== 1'b1);
      cyc_i <= 1'b0;
      stb_i <= 1'b0;
      we_i  <= 1'b0;
   endtask

   task automatic wr(input logic [31:0] a, input logic [31:0] d);
      wb(a, d, 1'b1, 4'hf);
   endtask

   task automatic rd(input logic [31:0] a, input logic [31:0] e);
      exp_q.push_back(e);
      wb(a, 32'h0, 1'b0, 4'hf);
   endtask

   function automatic logic [31:0] off(input int c, input int k);
      return (k < 3) ? CMP_OFF[c][k] : LEN_OFF[c];
   endfunction

   // Measures high time and period of one output in clock cycles; negative skips a check.
   task automatic meas(input int b, input int hi, input int per);
      int n, h, l;
      n = 0;
      h = 0;
      l = 0;
      while (pwm_out[b] !== 1'b0 && n < 10000) begin @(posedge clk_sys); n++; end
      while (pwm_out[b] !== 1'b1 && n < 10000) begin @(posedge clk_sys); n++; end
      while (pwm_out[b] === 1'b1 && n < 10000) begin @(posedge clk_sys); n++; h++; end
      while (pwm_out[b] !== 1'b1 && n < 10000) begin @(posedge clk_sys); n++; l++; end
      if (n >= 10000) begin
         num_errors++;
         $display("Error at %0t: output %0d never completed a period", $time, b);
      end
      if (hi >= 0) check(32'(h), 32'(hi));
      if (per >= 0) check(32'(h + l), 32'(per));
   endtask

   always @(posedge clk_sys) begin
      if (ack_o === 1'b1 && cyc_i === 1'b1 && we_i === 1'b0) begin
         if (exp_q.size() == 0) begin
            num_errors++;
            $display("Error at %0t: read data %h with nothing expected", $time, dat_o);
         end else begin
            check(dat_o, exp_q.pop_front());
         end
      end
   end

   initial begin
      repeat (60000) @(posedge clk_sys);
      num_errors++;
      $display("Error at %0t: watchdog expired", $time);
      end_sim();
   end

   // ************************************************************
   // Scenarios
   // ************************************************************
   initial begin
      {rstn, we_i, cyc_i, stb_i, fault_req} = 5'h0;
      adr_i = 32'h0;
      dat_i = 32'h0;
      sel_i = 4'h0;
      repeat (10) @(posedge clk_sys);
      rstn <= 1'b1;
      rd(CTRL_OFF, 32'h012);
      for (int c = 0; c < 3; c++) for (int k = 0; k < 4; k++) if (c != 2 || k != 2) begin
         rd(off(c, k), 32'h0);
         rv[c][k] = $random(seed);
         wr(off(c, k), rv[c][k]);
      end
      for (int c = 0; c < 3; c++) for (int k = 0; k < 4; k++) if (c != 2 || k != 2) begin
         rd(off(c, k), rv[c][k] & 32'h0000ffff);
      end
      wr(32'hffff0fac, $random(seed));
      rd(32'hffff0fac, 32'h0);
      rd(INT_CLEAR_STB_OFF, 32'h0);
      rd(IRQ_STATUS_OFF, 32'h0);
      for (int c = 0; c < 3; c++) for (int k = 0; k < 4; k++) if (c != 2 || k != 2) begin
         wr(off(c, k), 32'(pv[c][k]));
      end
      wr(CTRL_OFF, 32'h009);
      meas(0, 6, 16);
      meas(1, 8, 16);
      meas(2, 8, 20);
      meas(3, 10, 20);
      meas(4, 6, 16);
      wr(CTRL_OFF, 32'h001);
      wr(CH2_RISE_OFF, 32'h1);
      meas(4, 6, 16);
      wr(CTRL_OFF, 32'h009);
      meas(4, -1, -1);
      meas(4, 8, 16);
      for (int p = 0; p < 8; p++) begin
         wr(CTRL_OFF, 32'h001 | (p << PRESCALE_LSB));
         meas(4, -1, (2 << p) * 8);
      end
      for (int i = 0; i < 6; i++) begin
         wr(CTRL_OFF, {20'h0, bctl[i]});
         repeat (6) @(posedge clk_sys);
         check({28'h0, pwm_out[3:0] & bmsk[i]}, {28'h0, bexp[i]});
      end
      wr(CTRL_OFF, 32'h001);
      rd(IRQ_STATUS_OFF, 32'h2);
      check({31'h0, irq_o}, 32'h0);
      wr(IRQ_ENABLE_OFF, 32'h2);
      repeat (3) @(posedge clk_sys);
      check({31'h0, irq_o}, 32'h1);
      wr(CTRL_OFF, 32'h000);
      wr(IRQ_CLEAR_OFF, 32'h2);
      repeat (3) @(posedge clk_sys);
      check({31'h0, irq_o}, 32'h0);
      rd(IRQ_STATUS_OFF, 32'h0);
      wr(IRQ_ENABLE_OFF, 32'h1);
      wr(CTRL_OFF, 32'h5e1);
      repeat (2) @(posedge clk_sys);
      check({27'h0, pwm_out}, 32'h1f);
      fault_req <= 1'b1;
      repeat (10) @(posedge clk_sys);
      check({27'h0, pwm_out}, 32'h0);
      check({31'h0, irq_o}, 32'h1);
      fault_req <= 1'b0;
      repeat (8) @(posedge clk_sys);
      rd(CTRL_OFF, 32'h5e0);
      rd(IRQ_STATUS_OFF, 32'h1);
      wb(INT_CLEAR_STB_OFF, $random(seed), 1'b1, 4'($random(seed)));
      repeat (3) @(posedge clk_sys);
      check({31'h0, irq_o}, 32'h0);
      rd(IRQ_STATUS_OFF, 32'h0);
      repeat (4) @(posedge clk_sys);
      end_sim();
   end
endmodule
`default_nettype wire

// file: src/pin_sync3.sv
// Three-stage pin synchroniser that accepts a level once stages two and three agree.
`timescale 1ns/10ps
`default_nettype none
module pin_sync3 #(
   parameter logic RESET_VAL = 1'b1
) (
   input  wire logic clk_sys,   // System clock.
   input  wire logic rstn,      // Asynchronous reset, active low.
   input  wire logic pin_in,    // Asynchronous pin level.
   output var  logic level_out  // Filtered level in clk_sys domain.
);
   logic s1_r;
   logic s2_r;
   logic s3_r;

   always_ff @(posedge clk_sys or negedge rstn) begin
      if (!rstn) begin
         s1_r <= RESET_VAL;
         s2_r <= RESET_VAL;
         s3_r <= RESET_VAL;
      end else begin
         s1_r <= pin_in;
         s2_r <= s1_r;
         s3_r <= s2_r;
      end
   end

   always_ff @(posedge clk_sys or negedge rstn) begin
      if (!rstn) begin
         level_out <= RESET_VAL;
      end else if (s2_r == s3_r) begin
         level_out <= s3_r;
      end
   end
endmodule
`default_nettype wire

// file: src/pwm_unit_pkg.sv
// Register map, field layout and reset values of the three-pair PWM compare unit.
package pwm_unit_pkg;
   // ************************************************************
   // Widths
   // ************************************************************
   localparam int TIMER_W    = 16;
   localparam int PRESCALE_W = 3;
   localparam int PRE_CNT_W  = 8;
   localparam int IRQ_W      = 2;
   localparam int CTRL_W     = 11;

   // ************************************************************
   // Register byte addresses
   // ************************************************************
   localparam logic [31:0] CTRL_OFF           = 32'hffff0f80;
   localparam logic [31:0] CH0_RISE_OFF       = 32'hffff0f84;
   localparam logic [31:0] CH0_FALL_OFF       = 32'hffff0f88;
   localparam logic [31:0] CH0_PAIR_FALL_OFF  = 32'hffff0f8c;
   localparam logic [31:0] CH0_LENGTH_OFF     = 32'hffff0f90;
   localparam logic [31:0] CH1_RISE_OFF       = 32'hffff0f94;
   localparam logic [31:0] CH1_FALL_OFF       = 32'hffff0f98;
   localparam logic [31:0] CH1_PAIR_FALL_OFF  = 32'hffff0f9c;
   localparam logic [31:0] CH1_LENGTH_OFF     = 32'hffff0fa0;
   localparam logic [31:0] CH2_RISE_OFF       = 32'hffff0fa4;
   localparam logic [31:0] CH2_FALL_OFF       = 32'hffff0fa8;
   localparam logic [31:0] CH2_PERIOD_OFF     = 32'hffff0fb0;
   localparam logic [31:0] INT_CLEAR_STB_OFF  = 32'hffff0fb8;
   localparam logic [31:0] IRQ_STATUS_OFF     = 32'hffff0fc0;
   localparam logic [31:0] IRQ_ENABLE_OFF     = 32'hffff0fc4;
   localparam logic [31:0] IRQ_CLEAR_OFF      = 32'hffff0fc8;

   // Channel 2 has no pair output, so its third slot is never decoded.
   localparam logic [31:0] CMP_OFF [3][3] = '{
      '{CH0_RISE_OFF, CH0_FALL_OFF, CH0_PAIR_FALL_OFF},
      '{CH1_RISE_OFF, CH1_FALL_OFF, CH1_PAIR_FALL_OFF},
      '{CH2_RISE_OFF, CH2_FALL_OFF, 32'h00000000}};
   localparam logic [31:0] LEN_OFF [3] = '{CH0_LENGTH_OFF, CH1_LENGTH_OFF, CH2_PERIOD_OFF};

   // ************************************************************
   // Control register fields
   // ************************************************************
   localparam int GLOBAL_EN_BIT   = 0;
   localparam int BRIDGE_MODE_BIT = 1;
   localparam int DIRECTION_BIT   = 2;
   localparam int LOAD_REQ_BIT    = 3;
   localparam int HIGH_OFF_BIT    = 4;
   localparam int INVERT_BIT      = 5;
   localparam int PRESCALE_LSB    = 6;
   localparam int BRIDGE_EN_BIT   = 9;
   localparam int TRIP_EN_BIT     = 10;

   // ************************************************************
   // Interrupt status bits and reset values
   // ************************************************************
   localparam int IRQ_TRIP_BIT   = 0;
   localparam int IRQ_PERIOD_BIT = 1;

   localparam logic [CTRL_W-1:0]  CTRL_RESET  = 11'h012;
   localparam logic [TIMER_W-1:0] VALUE_RESET = 16'h0000;
   localparam logic [IRQ_W-1:0]   IRQ_RESET   = 2'h0;
endpackage

// file: src/three_pair_pwm_compare_unit.sv
// Three-channel PWM compare unit with H-bridge output stage and Wishbone register slave.
//
// Overview of operation
// - Bridge mode selects active, idle pair levels.
// - Output 0 rises at compare 0, falls compare 1.
// - Output 1 falls at compare 2, rises length.
// - Output 2 rises, falls on channel 1 compares.
// - Output 3 falls compare 2, rises length, channel 1.
// - Output 4 rises, falls on channel 2 compares.
// - Channel 2 period register sets output 4 period.
// - Any write to clear strobe clears trip interrupt.
// - Load request copies compares on step 0 to 1.
// - Enabled trip low clears global enable, interrupts.
// - Prescaler divides unit clock by 2 to 256.
`timescale 1ns/10ps
`default_nettype none
module three_pair_pwm_compare_unit
   import pwm_unit_pkg::*;
#(
   parameter int CNT_W = TIMER_W
) (
   input  wire logic        clk_sys,    // System clock, 40 MHz.
   input  wire logic        rstn,       // Asynchronous reset, active low.
   input  wire logic [31:0] adr_i,      // Wishbone byte address.
   input  wire logic [31:0] dat_i,      // Wishbone write data.
   output var  logic [31:0] dat_o,      // Wishbone read data.
   input  wire logic        we_i,       // Wishbone write enable.
   input  wire logic [3:0]  sel_i,      // Wishbone byte selects.
   input  wire logic        cyc_i,      // Wishbone cycle.
   input  wire logic        stb_i,      // Wishbone strobe.
   output var  logic        ack_o,      // Wishbone acknowledge.
   input  wire logic        trip_pin_n, // Trip input, active low.
   output var  logic [4:0]  pwm_out,    // PWM outputs 0 to 4.
   output var  logic        irq_o       // Interrupt, active high level.
);
   // ************************************************************
   // Parameter check
   // ************************************************************
   if (CNT_W < 2 || CNT_W > TIMER_W) begin : g_bad_width
      $error("CNT_W must lie between 2 and 16");
   end

   // ************************************************************
   // Storage
   // ************************************************************
   logic [CNT_W-1:0]     soft_cmp_r [3][3];
   logic [CNT_W-1:0]     cmp_r      [3][3];
   logic [CNT_W-1:0]     len_r      [3];
   logic [CNT_W-1:0]     cnt_r      [3];
   logic [CTRL_W-1:0]    ctrl_r;
   logic [IRQ_W-1:0]     stat_r;
   logic [IRQ_W-1:0]     ien_r;
   logic [PRE_CNT_W-1:0] pre_r;
   logic [4:0]           wave_r;
   logic [4:0]           out_nxt;
   logic [31:0]          rd_nxt;
   logic                 tick;
   logic                 tripped;
   logic                 trip_ev;
   logic                 period_ev;
   logic                 wr_go;
   logic                 gen;

   function automatic logic [15:0] lane_merge(input logic [15:0] old,
                                              input logic [31:0] dat,
                                              input logic [3:0]  sel);
      lane_merge = old;
      if (sel[0]) begin
         lane_merge[7:0] = dat[7:0];
      end
      if (sel[1]) begin
         lane_merge[15:8] = dat[15:8];
      end
   endfunction

   function automatic logic [PRE_CNT_W-1:0] pre_last(input logic [PRESCALE_W-1:0] code);
      logic [PRE_CNT_W:0] span;
      // Widened first: a 3-bit sum would wrap code 7 round to a divide by one.
      span = 9'h001 << (4'(code) + 4'h1);
      pre_last = PRE_CNT_W'(span - 9'h001);
   endfunction

   // ************************************************************
   // Wishbone slave
   // ************************************************************
   // One wait state: ack rises the cycle after the request, and writes
   // take effect on the edge where ack is high, as the master samples it.
   assign wr_go = cyc_i && stb_i && we_i && ack_o;
   assign gen   = ctrl_r[GLOBAL_EN_BIT];

   always_ff @(posedge clk_sys or negedge rstn) begin
      if (!rstn) begin
         ack_o <= 1'b0;
         dat_o <= 32'h00000000;
      end else begin
         ack_o <= cyc_i && stb_i && !ack_o;
         dat_o <= rd_nxt;
      end
   end

   always_comb begin
      rd_nxt = 32'h00000000;
      for (int c = 0; c < 3; c++) begin
         for (int s = 0; s < 3; s++) begin
            if (!(c == 2 && s == 2) && adr_i == CMP_OFF[c][s]) begin
               rd_nxt = 32'(soft_cmp_r[c][s]);
            end
         end
         if (adr_i == LEN_OFF[c]) begin
            rd_nxt = 32'(len_r[c]);
         end
      end
      case (adr_i)
         CTRL_OFF:       rd_nxt = 32'(ctrl_r);
         IRQ_STATUS_OFF: rd_nxt = 32'(stat_r);
         IRQ_ENABLE_OFF: rd_nxt = 32'(ien_r);
         default:        rd_nxt = rd_nxt;
      endcase
   end

   always_ff @(posedge clk_sys or negedge rstn) begin
      if (!rstn) begin
         for (int c = 0; c < 3; c++) begin
            len_r[c] <= CNT_W'(VALUE_RESET);
            for (int s = 0; s < 3; s++) begin
               soft_cmp_r[c][s] <= CNT_W'(VALUE_RESET);
            end
         end
      end else if (wr_go) begin
         for (int c = 0; c < 3; c++) begin
            for (int s = 0; s < 3; s++) begin
               if (!(c == 2 && s == 2) && adr_i == CMP_OFF[c][s]) begin
                  soft_cmp_r[c][s] <= CNT_W'(lane_merge(16'(soft_cmp_r[c][s]), dat_i, sel_i));
               end
            end
            if (adr_i == LEN_OFF[c]) begin
               len_r[c] <= CNT_W'(lane_merge(16'(len_r[c]), dat_i, sel_i));
            end
         end
      end
   end

   // ************************************************************
   // Control register and trip
   // ************************************************************
   pin_sync3 #(
      .RESET_VAL (1'b1)
   ) u_trip_sync (
      .clk_sys   (clk_sys),
      .rstn      (rstn),
      .pin_in    (trip_pin_n),
      .level_out (tripped)
   );

   assign trip_ev = ctrl_r[TRIP_EN_BIT] && !tripped;

   // The trip wins over a software write so that a write cannot re-enable
   // the outputs while the power stage is still signalling a fault.
   always_ff @(posedge clk_sys or negedge rstn) begin
      if (!rstn) begin
         ctrl_r <= CTRL_RESET;
      end else begin
         if (wr_go && adr_i == CTRL_OFF) begin
            ctrl_r <= CTRL_W'(lane_merge(16'(ctrl_r), dat_i, sel_i));
         end
         if (trip_ev) begin
            ctrl_r[GLOBAL_EN_BIT] <= 1'b0;
         end
      end
   end

   // ************************************************************
   // Prescaler and timers
   // ************************************************************
   assign tick = gen && (pre_r >= pre_last(ctrl_r[PRESCALE_LSB +: PRESCALE_W]));

   always_ff @(posedge clk_sys or negedge rstn) begin
      if (!rstn) begin
         pre_r <= '0;
      end else if (!gen || tick) begin
         pre_r <= '0;
      end else begin
         pre_r <= pre_r + 8'h01;
      end
   end

   always_ff @(posedge clk_sys or negedge rstn) begin
      if (!rstn) begin
         for (int c = 0; c < 3; c++) begin
            cnt_r[c] <= '0;
         end
      end else begin
         for (int c = 0; c < 3; c++) begin
            if (!gen) begin
               cnt_r[c] <= '0;
            end else if (tick) begin
               cnt_r[c] <= (cnt_r[c] == len_r[c]) ? '0 : cnt_r[c] + 1'b1;
            end
         end
      end
   end

   always_ff @(posedge clk_sys or negedge rstn) begin
      if (!rstn) begin
         for (int c = 0; c < 3; c++) begin
            for (int s = 0; s < 3; s++) begin
               cmp_r[c][s] <= CNT_W'(VALUE_RESET);
            end
         end
      end else begin
         for (int c = 0; c < 3; c++) begin
            if (tick && ctrl_r[LOAD_REQ_BIT] && cnt_r[c] == '0 && len_r[c] != '0) begin
               cmp_r[c] <= soft_cmp_r[c];
            end
         end
      end
   end

   // ************************************************************
   // Waveforms
   // ************************************************************
   // Where two compares hit the same count, the falling edge wins.
   always_ff @(posedge clk_sys or negedge rstn) begin
      if (!rstn) begin
         wave_r <= '0;
      end else if (!gen) begin
         wave_r <= '0;
      end else if (tick) begin
         for (int c = 0; c < 3; c++) begin
            if (cnt_r[c] == cmp_r[c][0]) begin
               wave_r[2*c] <= 1'b1;
            end
            if (cnt_r[c] == cmp_r[c][1]) begin
               wave_r[2*c] <= 1'b0;
            end
            if (c < 2) begin
               if (cnt_r[c] == len_r[c]) begin
                  wave_r[2*c+1] <= 1'b1;
               end
               if (cnt_r[c] == cmp_r[c][2]) begin
                  wave_r[2*c+1] <= 1'b0;
               end
            end
         end
      end
   end

   // ************************************************************
   // Output stage
   // ************************************************************
   always_comb begin
      logic hs;
      logic ls;
      logic inv;
      hs      = wave_r[0];
      ls      = wave_r[1];
      inv     = ctrl_r[INVERT_BIT];
      out_nxt = wave_r ^ {5{inv}};
      if (ctrl_r[BRIDGE_MODE_BIT]) begin
         case ({ctrl_r[HIGH_OFF_BIT], ctrl_r[BRIDGE_EN_BIT], inv, ctrl_r[DIRECTION_BIT]})
            4'h0, 4'h1, 4'h2, 4'h3: out_nxt[3:0] = 4'hf;
            4'h4:                   out_nxt[3:0] = {ls, hs, 2'b00};
            4'h5:                   out_nxt[3:0] = {2'b00, ls, hs};
            4'h6:                   out_nxt[3:0] = {2'b11, ls, hs};
            4'h7:                   out_nxt[3:0] = {ls, hs, 2'b11};
            default:                out_nxt[3:0] = 4'h5;
         endcase
      end
      if (!gen) begin
         out_nxt = '0;
      end
   end

   always_ff @(posedge clk_sys or negedge rstn) begin
      if (!rstn) begin
         pwm_out <= '0;
      end else begin
         pwm_out <= out_nxt;
      end
   end

   // ************************************************************
   // Interrupts
   // ************************************************************
   assign period_ev = tick && cnt_r[2] == len_r[2];

   // A new event in the cycle of a clear keeps its bit set.
   always_ff @(posedge clk_sys or negedge rstn) begin
      if (!rstn) begin
         stat_r <= IRQ_RESET;
         ien_r  <= IRQ_RESET;
      end else begin
         logic [IRQ_W-1:0] clr;
         clr = '0;
         if (wr_go && adr_i == IRQ_CLEAR_OFF && sel_i[0]) begin
            clr = dat_i[IRQ_W-1:0];
         end
         if (wr_go && adr_i == INT_CLEAR_STB_OFF) begin
            clr[IRQ_TRIP_BIT] = 1'b1;
         end
         stat_r <= (stat_r & ~clr) | {period_ev, trip_ev};
         if (wr_go && adr_i == IRQ_ENABLE_OFF && sel_i[0]) begin
            ien_r <= dat_i[IRQ_W-1:0];
         end
      end
   end

   always_ff @(posedge clk_sys or negedge rstn) begin
      if (!rstn) begin
         irq_o <= 1'b0;
      end else begin
         irq_o <= |(stat_r & ien_r);
      end
   end

   // ************************************************************
   // Assertions
   // ************************************************************
   a_bridge_idle_high: assert property (@(posedge clk_sys) disable iff (!rstn)
      gen && ctrl_r[BRIDGE_MODE_BIT] && !ctrl_r[HIGH_OFF_BIT] && !ctrl_r[BRIDGE_EN_BIT]
      |=> pwm_out[3:0] == 4'hf || !$past(gen))
      else $error("idle bridge outputs not high");

   a_out0_rise: assert property (@(posedge clk_sys) disable iff (!rstn)
      tick && cnt_r[0] == cmp_r[0][0] && cnt_r[0] != cmp_r[0][1] |=> wave_r[0])
      else $error("output 0 missed rise");

   a_out1_fall: assert property (@(posedge clk_sys) disable iff (!rstn)
      tick && cnt_r[0] == cmp_r[0][2] |=> !wave_r[1])
      else $error("output 1 missed fall");

   a_out2_fall: assert property (@(posedge clk_sys) disable iff (!rstn)
      tick && cnt_r[1] == cmp_r[1][1] |=> !wave_r[2])
      else $error("output 2 missed fall");

   a_out3_rise: assert property (@(posedge clk_sys) disable iff (!rstn)
      tick && cnt_r[1] == len_r[1] && cnt_r[1] != cmp_r[1][2] |=> wave_r[3])
      else $error("output 3 missed rise");

   a_out4_period: assert property (@(posedge clk_sys) disable iff (!rstn)
      tick && cnt_r[2] == len_r[2] |=> cnt_r[2] == '0)
      else $error("output 4 period not wrapped");

   a_clear_strobe: assert property (@(posedge clk_sys) disable iff (!rstn)
      wr_go && adr_i == INT_CLEAR_STB_OFF && !trip_ev |=> !stat_r[IRQ_TRIP_BIT])
      else $error("clear strobe left interrupt pending");

   a_compare_load: assert property (@(posedge clk_sys) disable iff (!rstn)
      tick && ctrl_r[LOAD_REQ_BIT] && cnt_r[0] == '0 && len_r[0] != '0
      |=> cmp_r[0][1] == $past(soft_cmp_r[0][1]) ##1 cnt_r[0] == 1 || !gen)
      else $error("compare values not loaded");

   a_trip_stop: assert property (@(posedge clk_sys) disable iff (!rstn)
      trip_ev |=> !gen && stat_r[IRQ_TRIP_BIT] ##1 pwm_out == 5'h00)
      else $error("trip did not stop outputs");

   a_prescale_div2: assert property (@(posedge clk_sys) disable iff (!rstn)
      tick ##1 (gen && ctrl_r[PRESCALE_LSB +: PRESCALE_W] == 3'h0)
      ##1 (gen && ctrl_r[PRESCALE_LSB +: PRESCALE_W] == 3'h0) |-> tick && !$past(tick))
      else $error("divide by two spacing wrong");

   a_timer_step: assert property (@(posedge clk_sys) disable iff (!rstn)
      tick && cnt_r[1] != len_r[1] |=> cnt_r[1] == $past(cnt_r[1]) + 1'b1 || !gen)
      else $error("timer did not step");
endmodule
`default_nettype wire
